// *** core/ipf_field.sv ***
`timescale 1ns/1ps
`include "ipf_map.svh"
// one 3-bit priority field
module ipf_field
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // field access
  ipf_field_if.fld port
);
  ipf_pkg::ipf_prio_t prio_q;
  ipf_pkg::ipf_prio_t prio_d;
  // next value: every code 0..7 accepted as written
  always_comb
  begin
    prio_d = prio_q;
    if (port.wr)
      prio_d = port.wdata;
  end
  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prio_q <= `IPF_PRIO_RST; // [RULE7]
    else if (clk_en)
      prio_q <= prio_d;
  end
  assign port.value = prio_q;
endmodule // ipf_field

// *** core/ipf_field_if.sv ***
`timescale 1ns/1ps
interface ipf_field_if;
  logic wr;
  logic [2:0] wdata;
  logic [2:0] value;
  modport ctl (output wr, output wdata, input value);
  modport fld (input wr, input wdata, output value);
endinterface

// *** core/ipf_map.svh ***
`ifndef IPF_MAP_SVH
`define IPF_MAP_SVH
// register byte offsets
`define IPF_UART_ERR_OFS 12'h000
`define IPF_LOW_VOLT_OFS 12'h004
`define IPF_CHARGE_OFS 12'h008
// field positions (lsb)
`define IPF_SER2_LSB 8
`define IPF_SER1_LSB 4
`define IPF_BROWN_LSB 0
`define IPF_CTU_LSB 4
// field reset value: priority four
`define IPF_PRIO_RST 3'h4
`define IPF_PRIO_OFF 3'h0
`define IPF_PRIO_MAX 3'h7
`define IPF_ADDR_LSB 2
// field geometry
`define IPF_NUM_FIELDS 4
`define IPF_FLD_W 3
`define IPF_LANE_W 8
`define IPF_REG_W 16
// address width limits served by the 12-bit offsets
`define IPF_ADDR_W_MIN 4
`define IPF_ADDR_W_MAX 12
`endif

// *** core/ipf_pkg.sv ***
package ipf_pkg;
  typedef logic [2:0] ipf_prio_t;
  typedef enum logic [1:0] {IPF_SRC_SER2, IPF_SRC_SER1, IPF_SRC_BROWN, IPF_SRC_CTU} ipf_src_t;
endpackage

// *** core/ipf_prio_regs.sv ***
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "ipf_map.svh"
// Operation
// [RULE1] code 7 is highest level seven
// [RULE2] code 1 is lowest active level
// [RULE3] code 0 disables source from arbitration
// [RULE4] brownout field in bits 2..0, rw
// [RULE5] charge-time field in bits 6..4, rw
// [RULE6] unimplemented bits read zero, ignore writes
// [RULE7] serial2 bits 10..8, serial1 6..4, reset 4
module ipf_prio_regs
#(
  parameter int ADDR_W = 12
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // to arbitration
  output logic [2:0] serial2_error_prio,
  output logic [2:0] serial1_error_prio,
  output logic [2:0] brownout_warn_prio,
  output logic [2:0] charge_time_unit_prio,
  output logic [3:0] src_active
);
  // ==========================================
  // parameter check
  // offsets are 12-bit constants, so a wider bus cannot be compared with them
  generate
    if (ADDR_W < `IPF_ADDR_W_MIN || ADDR_W > `IPF_ADDR_W_MAX)
    begin : g_bad_addr_w
      $error("ipf_prio_regs: ADDR_W must lie in 4..12");
    end
  endgenerate

  // ==========================================
  // decode helpers
  // word compare only; the two low address bits select nothing
  function automatic logic addr_is
  (
    input logic [ADDR_W-1:0] a,
    input logic [11:0] ofs
  );
    addr_is = (a[ADDR_W-1:`IPF_ADDR_LSB] == ofs[ADDR_W-1:`IPF_ADDR_LSB]);
  endfunction

  // bit position of each source inside its own register
  function automatic int fld_lsb
  (
    input int idx
  );
    case (idx)
      int'(ipf_pkg::IPF_SRC_SER2):
        fld_lsb = `IPF_SER2_LSB; // [RULE7]
      int'(ipf_pkg::IPF_SRC_SER1):
        fld_lsb = `IPF_SER1_LSB; // [RULE7]
      int'(ipf_pkg::IPF_SRC_BROWN):
        fld_lsb = `IPF_BROWN_LSB; // [RULE4]
      int'(ipf_pkg::IPF_SRC_CTU):
        fld_lsb = `IPF_CTU_LSB; // [RULE5]
      default:
        fld_lsb = `IPF_BROWN_LSB;
    endcase
  endfunction

  // byte lane that carries the bit at position lsb
  function automatic int lane_of
  (
    input int lsb
  );
    lane_of = lsb / `IPF_LANE_W;
  endfunction

  // a field split over two lanes could be half written by a narrow store
  genvar c;
  generate
    for (c = 0; c < `IPF_NUM_FIELDS; c++)
    begin : g_chk
      if (lane_of(fld_lsb(c)) != lane_of(fld_lsb(c) + `IPF_FLD_W - 1))
      begin : g_bad_lane
        $error("ipf_prio_regs: field straddles a byte lane");
      end
      if (fld_lsb(c) + `IPF_FLD_W > `IPF_REG_W)
      begin : g_bad_pos
        $error("ipf_prio_regs: field beyond the register width");
      end
    end
  endgenerate

  // the two serial fields share one register and must not overlap
  generate
    if (`IPF_SER1_LSB + `IPF_FLD_W > `IPF_SER2_LSB)
    begin : g_bad_overlap
      $error("ipf_prio_regs: serial fields overlap");
    end
  endgenerate

  // a reset code of zero would start every source switched off
  generate
    if (`IPF_PRIO_RST == `IPF_PRIO_OFF)
    begin : g_bad_rst
      $error("ipf_prio_regs: reset code disables the sources");
    end
  endgenerate

  // ==========================================
  // address and access qualifiers
  logic access;
  logic rd_setup;
  logic hit_uart;
  logic hit_volt;
  logic hit_chg;
  logic mapped;
  logic [`IPF_NUM_FIELDS-1:0] fld_hit;
  // writes need the access phase and a running clock
  assign access = psel && penable && clk_en;
  // reads are captured one edge early, in the setup cycle
  assign rd_setup = psel && !penable && !pwrite && clk_en;
  assign hit_uart = addr_is(paddr, `IPF_UART_ERR_OFS);
  assign hit_volt = addr_is(paddr, `IPF_LOW_VOLT_OFS);
  assign hit_chg = addr_is(paddr, `IPF_CHARGE_OFS);
  assign mapped = hit_uart || hit_volt || hit_chg;

  // which register each field lives in
  always_comb
  begin
    fld_hit = '0;
    fld_hit[ipf_pkg::IPF_SRC_SER2] = hit_uart;
    fld_hit[ipf_pkg::IPF_SRC_SER1] = hit_uart;
    fld_hit[ipf_pkg::IPF_SRC_BROWN] = hit_volt;
    fld_hit[ipf_pkg::IPF_SRC_CTU] = hit_chg;
  end

  // ==========================================
  // handshake
  // zero-wait slave; unmapped addresses answer with an error, store nothing
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // ==========================================
  // field writes: byte lanes honoured
  // limitation: with clk_en low a transfer still completes but is ignored
  logic [`IPF_NUM_FIELDS-1:0] wr_en;
  ipf_pkg::ipf_prio_t [`IPF_NUM_FIELDS-1:0] wdata;
  ipf_pkg::ipf_prio_t [`IPF_NUM_FIELDS-1:0] value;
  // unimplemented bits never reach a field, so writes to them vanish
  always_comb
  begin
    for (int i = 0; i < `IPF_NUM_FIELDS; i++)
    begin
      wr_en[i] = access && pwrite && fld_hit[i] && pstrb[lane_of(fld_lsb(i))];
      wdata[i] = pwdata[fld_lsb(i) +: `IPF_FLD_W]; // [RULE6]
    end
  end

  // one storage instance per source
  genvar g;
  generate
    for (g = 0; g < `IPF_NUM_FIELDS; g++)
    begin : g_fld
      ipf_field_if fif ();
      assign fif.wr = wr_en[g];
      assign fif.wdata = wdata[g];
      assign value[g] = fif.value;
      ipf_field u_fld
      (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .port(fif)
      );
      // zero code keeps the source out of arbitration; 1..7 pass as levels
      assign src_active[g] = (value[g] != `IPF_PRIO_OFF); // [RULE3]
    end
  endgenerate

  // ==========================================
  // outputs to arbitration
  // levels equal codes: 7 highest, 1 lowest active, 0 off
  assign serial2_error_prio = value[ipf_pkg::IPF_SRC_SER2]; // [RULE1]
  assign serial1_error_prio = value[ipf_pkg::IPF_SRC_SER1]; // [RULE2]
  assign brownout_warn_prio = value[ipf_pkg::IPF_SRC_BROWN];
  assign charge_time_unit_prio = value[ipf_pkg::IPF_SRC_CTU];

  // ==========================================
  // read data, registered at the setup edge
  // captured early so prdata is a flop output through the access phase
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  always_comb
  begin
    rdata_d = rdata_q;
    if (rd_setup)
    begin
      rdata_d = 32'h0000_0000; // [RULE6]
      for (int i = 0; i < `IPF_NUM_FIELDS; i++)
      begin
        if (fld_hit[i])
          rdata_d[fld_lsb(i) +: `IPF_FLD_W] = value[i];
      end
    end
  end

  // read register; holds while clk_en is low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rdata_q <= 32'h0000_0000;
    else if (clk_en)
      rdata_q <= rdata_d;
  end
  assign prdata = rdata_q;
endmodule // ipf_prio_regs

// *** tb/ipf_prio_regs_checker.sv ***
`timescale 1ns/1ps
// ==========================================
// checker on the top-level ports
module ipf_checker
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // priorities
  input wire logic [2:0] serial2_error_prio,
  input wire logic [2:0] serial1_error_prio,
  input wire logic [2:0] brownout_warn_prio,
  input wire logic [2:0] charge_time_unit_prio,
  input wire logic [3:0] src_active
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // a write the slave takes at this edge
  logic w;
  logic [2:0] c;
  assign w = psel & penable & pwrite & clk_en;
  assign c = charge_time_unit_prio;
  property p_act;
    src_active == {c != 3'h0, brownout_warn_prio != 3'h0,
      serial1_error_prio != 3'h0, serial2_error_prio != 3'h0};
  endproperty
  a_act: assert property (p_act) else $error("source flags wrong");
  property p_bo;
    w && paddr == 12'h004 && pstrb[0] |=> brownout_warn_prio == $past(pwdata[2:0]);
  endproperty
  a_bo: assert property (p_bo) else $error("brownout field wrong");
  property p_ct;
    w && paddr == 12'h008 && pstrb[0] |=> c == $past(pwdata[6:4]);
  endproperty
  a_ct: assert property (p_ct) else $error("charge field wrong");
  property p_s2;
    w && paddr == 12'h000 && pstrb[1] |=> serial2_error_prio == $past(pwdata[10:8]);
  endproperty
  a_s2: assert property (p_s2) else $error("serial2 field wrong");
  property p_s1;
    w && paddr == 12'h000 && pstrb[0] |=> serial1_error_prio == $past(pwdata[6:4]);
  endproperty
  a_s1: assert property (p_s1) else $error("serial1 field wrong");
  property p_rd;
    psel && penable && !pwrite && paddr == 12'h008 |-> prdata[31:7] == 25'h0 && prdata[3:0] == 4'h0;
  endproperty
  a_rd: assert property (p_rd) else $error("unused bits read nonzero");
  property p_rst;
    $rose(presetn) |-> serial2_error_prio == 3'h4 && serial1_error_prio == 3'h4 &&
      brownout_warn_prio == 3'h4 && c == 3'h4;
  endproperty
  a_rst: assert property (p_rst) else $error("reset level wrong");
  property p_err;
    psel && penable && paddr == 12'h00C |-> pslverr;
  endproperty
  a_err: assert property (p_err) else $error("unmapped not refused");
  // covers
  c_7: cover property (c == 3'h7);
  c_0: cover property (c == 3'h0);
  c_1: cover property (c == 3'h1);
  c_err: cover property (psel && penable && pslverr);
endmodule // ipf_checker

// *** tb/tb_ipf_prio_regs.sv ***
`timescale 1ns/1ps
// ==
// bench
module tb_ipf_prio_regs;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, clk_en = 1;
  logic [3:0] pstrb = 4'h0, ws;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, d, bm, m[4];
  logic [31:0] mk[4] = '{32'h770, 32'h7, 32'h70, 32'h0};
  logic er;
  wire [31:0] prdata;
  wire pready, pslverr;
  wire [2:0] serial2_error_prio, serial1_error_prio, brownout_warn_prio, charge_time_unit_prio;
  wire [3:0] src_active;
  int fails, checks_done, seed = 58, k;
  always #12.5 pclk = ~pclk;
  ipf_prio_regs ipf_prio_regs_inst (.*);
  task chk(logic [31:0] g, x);
    checks_done++;
    if (g !== x)
    begin
      fails++;
      $display("[ERR] %0t %h %h", $time, g, x);
    end
  endtask
  // model reset: every field at priority four
  task model_reset();
    m = '{32'h440, 32'h4, 32'h40, 32'h0};
  endtask
  // expected arbitration view from the model registers
  function automatic logic [31:0] exp_out();
    logic [2:0] s2, s1, bo, ct;
    s2 = m[0][10:8];
    s1 = m[0][6:4];
    bo = m[1][2:0];
    ct = m[2][6:4];
    exp_out = {16'h0, ct != 3'h0, bo != 3'h0, s1 != 3'h0, s2 != 3'h0, s2, s1, bo, ct};
  endfunction
  function automatic logic [31:0] cur_out();
    cur_out = {16'h0, src_active, serial2_error_prio, serial1_error_prio,
      brownout_warn_prio, charge_time_unit_prio};
  endfunction
  // apb cycle
  task apb(logic w, int a, logic [31:0] v, logic [3:0] s);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, w, 12'(a), v, s};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    d = prdata;
    er = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  // read back, random writes with random lanes
  initial
  begin
    model_reset();
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 40; i++)
    begin
      k = i % 4;
      apb(1'b0, k * 4, 32'h0, 4'h0);
      chk(d, m[k]);
      chk(32'(er), 32'(k == 3));
      chk(cur_out(), exp_out());
      d = $random(seed);
      d[6:4] = 3'(i / 4);
      ws = 4'($random(seed)) | 4'h1;
      bm = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
      m[k] = (m[k] & ~(mk[k] & bm)) | (d & mk[k] & bm);
      apb(1'b1, k * 4, d, ws);
    end
    // frozen clock enable: the write is not taken
    clk_en <= 1'b0;
    apb(1'b1, 4, 32'hFFFF, 4'hF);
    clk_en <= 1'b1;
    apb(1'b0, 4, 32'h0, 4'h0);
    chk(d, m[1]);
    // second reset in mid-run: all fields back to four
    @(posedge pclk);
    presetn <= 1'b0;
    model_reset();
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(cur_out(), exp_out());
    for (int j = 0; j < 4; j++)
    begin
      apb(1'b0, j * 4, 32'h0, 4'h0);
      chk(d, m[j]);
    end
    end_sim();
  end
  // watchdog
  initial
  begin
    #40us;
    fails++;
    end_sim();
  end
  task end_sim();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
endmodule // tb_ipf_prio_regs
bind ipf_prio_regs ipf_checker ipf_checker_inst (.*);
